// [verilog/fia_access_ctrl.sv]
/*
  Flash in-application access control: special registers, permission gating of
  data-space and code-space flash accesses, and the core stall during a write.
  Assumes a flash macro with combinational read and a one-cycle byte-write
  strobe, and a core that holds its request while stalled.
*/
`default_nettype none

module fia_access_ctrl
    import fia_pkg::*;
#(
    parameter int WRITE_CYC = WRITE_CYCLES,
    parameter int CNT_W = 16
)
(
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // special register port
    input wire logic [7:0] sfrAddr,
    input wire logic sfrWrEn,
    input wire logic [7:0] sfrWrData,
    input wire logic sfrRdEn,
    output logic [7:0] sfrRdData,
    output logic sfrRdHit,
    // external-data moves
    input wire logic [15:0] xAddr,
    input wire logic xWrEn,
    input wire logic [7:0] xWrData,
    input wire logic xRdEn,
    output logic [7:0] xRdData,
    output logic xDenied,
    // code-space moves
    input wire logic [FLASH_AW-1:0] codeAddr,
    input wire logic codeRdEn,
    output logic [7:0] codeRdData,
    output logic codeDenied,
    // core control
    output logic coreStall,
    output logic irqHold,
    // configuration bytes from flash
    input wire logic [7:0] cfgLowByte,
    input wire logic [7:0] cfgHighByte,
    output logic [7:0] ctrlLowByte,
    // flash macro
    output logic [FLASH_AW-1:0] flashRdAddr,
    input wire logic [7:0] flashRdData,
    output logic flashWrEn,
    output logic [FLASH_AW-1:0] flashWrAddr,
    output logic [7:0] flashWrData
);

    logic [1:0] rstSync_q;
    logic rstn;
    fia_state_s st_q;
    fia_state_s st_d;
    logic xFlash;
    logic xOk;
    logic codeOk;
    logic timerBusy;
    logic wrReq;
    logic wrOk;
    logic rdReq;

    // reset released through two flip-flops
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            rstSync_q <= 2'h0;
        else
            rstSync_q <= {rstSync_q[0], 1'b1};
    end

    assign rstn = rstSync_q[1];

    assign xFlash = xAddr[15:14] == FLASH_WINDOW;

    fia_region_check u_data_region (
        .addr (xAddr[FLASH_AW-1:0]),
        .dataSpace (1'b1),
        .lock (st_q.lock),
        .wide (st_q.wide),
        .allowed (xOk)
    );

    fia_region_check u_code_region (
        .addr (codeAddr),
        .dataSpace (1'b0),
        .lock (st_q.lock),
        .wide (st_q.wide),
        .allowed (codeOk)
    );

    fia_write_timer #(
        .CYCLES (WRITE_CYC),
        .CNT_W (CNT_W)
    ) u_write_timer (
        .core_clk (core_clk),
        .rstn (rstn),
        .start (wrOk),
        .busy (timerBusy)
    );

    // a request arriving while the write runs is held off by the stall
    assign wrReq = xWrEn && xFlash && !timerBusy;
    assign wrOk = wrReq && xOk && st_q.arm;
    assign rdReq = xRdEn && xFlash && !timerBusy;

    // single read port: data-space read has the address when both arrive
    assign flashRdAddr = (xRdEn && xFlash) ? xAddr[FLASH_AW-1:0] : codeAddr;

    always_comb
    begin
        st_d = st_q;
        st_d.sfrHit = 1'b0;
        st_d.xDen = 1'b0;
        st_d.codeDen = 1'b0;
        st_d.wrPulse = 1'b0;

        // configuration capture in the first cycle after release
        if (!st_q.loaded)
        begin
            st_d.loaded = 1'b1;
            st_d.ctrlLow = cfgLowByte;
            st_d.lock = cfgHighByte[LOCK_BIT];
        end

        // special register writes
        if (sfrWrEn)
        begin
            case (sfrAddr)
                SFR_SOFT_CMD:
                    st_d.wide = sfrWrData == WIDE_UNLOCK_KEY;
                SFR_WRITE_ARM:
                    st_d.arm = sfrWrData == WRITE_ARM_KEY;
                SFR_CTRL_LOW:
                    st_d.ctrlLow = sfrWrData;
                default:
                    st_d.ctrlLow = st_d.ctrlLow;
            endcase
        end

        // special register reads, answered one cycle later
        if (sfrRdEn)
        begin
            st_d.sfrRd = 8'h00;
            st_d.sfrHit = 1'b1;
            case (sfrAddr)
                SFR_SOFT_CMD:
                    st_d.sfrRd[WIDE_BIT] = st_q.wide;
                SFR_WRITE_ARM:
                    st_d.sfrRd[ARM_BIT] = st_q.arm;
                SFR_CTRL_LOW:
                    st_d.sfrRd = st_q.ctrlLow;
                default:
                    st_d.sfrHit = 1'b0;
            endcase
        end

        // data-space byte write: no erase, one byte per request
        if (wrOk)
        begin
            st_d.wrPulse = 1'b1;
            st_d.wrAddr = xAddr[FLASH_AW-1:0];
            st_d.wrData = xWrData;
        end

        // forbidden data access is flagged and goes nowhere
        if ((wrReq || rdReq) && !xOk)
            st_d.xDen = 1'b1;

        // data-space read with no added wait
        if (rdReq)
            st_d.xRd = xOk ? flashRdData : 8'h00;

        // code-space read with no added wait
        if (codeRdEn && !timerBusy)
        begin
            st_d.codeRd = codeOk ? flashRdData : 8'h00;
            st_d.codeDen = !codeOk;
        end
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            st_q <= '0;
            st_q.wide <= WIDE_RST;
            st_q.arm <= ARM_RST;
            st_q.lock <= LOCK_RST;
            st_q.ctrlLow <= CTRL_LOW_RST;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign sfrRdData = st_q.sfrRd;
    assign sfrRdHit = st_q.sfrHit;
    assign xRdData = st_q.xRd;
    assign xDenied = st_q.xDen;
    assign codeRdData = st_q.codeRd;
    assign codeDenied = st_q.codeDen;
    assign ctrlLowByte = st_q.ctrlLow;
    assign flashWrEn = st_q.wrPulse;
    assign flashWrAddr = st_q.wrAddr;
    assign flashWrData = st_q.wrData;
    // the core halts while the write runs; timers and other blocks do not
    assign coreStall = timerBusy;
    // interrupts raised during the stall wait for the core to resume
    assign irqHold = timerBusy;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    a_write_path: assert property (
        wrOk |=> flashWrEn && flashWrData == $past(xWrData)
            && flashWrAddr == $past(xAddr[FLASH_AW-1:0]))
        else $error("accepted write did not reach flash");
    a_arm_gate: assert property (
        xWrEn && xFlash && !coreStall && !st_q.arm |=> !flashWrEn)
        else $error("write passed with arm flag clear");
    a_stall_start: assert property (
        flashWrEn |-> coreStall && irqHold)
        else $error("no stall during flash write");
    a_irq_release: assert property (
        $fell(coreStall) |-> !irqHold && !$past(flashWrEn))
        else $error("interrupts still held after write");
    a_read_no_wait: assert property (
        rdReq && xOk |=> !coreStall && xRdData == $past(flashRdData))
        else $error("permitted read stalled or wrong");
    a_reset_narrow: assert property (
        $rose(rstn) |-> !st_q.wide ##1 !st_q.wide)
        else $error("wide flag set after reset");
    a_lock_block: assert property (
        codeRdEn && !coreStall && st_q.lock && codeAddr <= LOCK_AREA_END
        |=> codeDenied && codeRdData == 8'h00)
        else $error("locked code read not blocked");
    a_main_gate: assert property (
        rdReq && !st_q.wide && xAddr[FLASH_AW-1:0] > LOCK_AREA_END
        && xAddr[FLASH_AW-1:0] <= MAIN_AREA_END |=> xDenied)
        else $error("main area open without wide flag");
    a_free_open: assert property (
        rdReq && xAddr[FLASH_AW-1:0] > MAIN_AREA_END
        && xAddr[FLASH_AW-1:0] <= FREE_AREA_END |=> !xDenied)
        else $error("free area refused");
    a_top_cfg: assert property (
        (rdReq || wrReq) && xAddr[FLASH_AW-1:0] == CFG_TOP_ADDR
        |=> xDenied && !flashWrEn)
        else $error("top config byte reachable by data move");
    a_wide_key: assert property (
        sfrWrEn && sfrAddr == SFR_SOFT_CMD
        |=> st_q.wide == ($past(sfrWrData) == WIDE_UNLOCK_KEY))
        else $error("soft command key mishandled");
    a_wide_read: assert property (
        sfrRdEn && sfrAddr == SFR_SOFT_CMD
        |=> sfrRdHit && sfrRdData == {7'h00, $past(st_q.wide)})
        else $error("soft command read wrong");
    a_arm_key: assert property (
        sfrWrEn && sfrAddr == SFR_WRITE_ARM
        |=> st_q.arm == ($past(sfrWrData) == WRITE_ARM_KEY))
        else $error("write-arm key mishandled");
    a_arm_read: assert property (
        sfrRdEn && sfrAddr == SFR_WRITE_ARM
        |=> sfrRdData == {$past(st_q.arm), 7'h00})
        else $error("write-arm read wrong");
    a_cfg_copy: assert property (
        $rose(rstn) |=> ctrlLowByte == $past(cfgLowByte)
            && st_q.lock == $past(cfgHighByte[LOCK_BIT]))
        else $error("configuration byte not captured");
    a_deny_no_stall: assert property (
        wrReq && !xOk |=> !flashWrEn && !coreStall && xDenied)
        else $error("forbidden write acted");
    a_one_byte: assert property (
        flashWrEn |=> !flashWrEn)
        else $error("write strobe longer than one byte");

    // permission corners seen from the response side
    a_lock_data: assert property (
        rdReq && xAddr[FLASH_AW-1:0] <= LOCK_AREA_END && (st_q.lock || !st_q.wide)
        |=> xDenied)
        else $error("lock area open to data move");
    a_cfg_low_gate: assert property (
        rdReq && !st_q.wide && xAddr[FLASH_AW-1:0] > FREE_AREA_END
        |=> xDenied)
        else $error("config bytes open without wide flag");
    a_code_open: assert property (
        codeRdEn && !coreStall && !xRdEn && codeAddr > LOCK_AREA_END
        |=> !codeDenied && codeRdData == $past(flashRdData))
        else $error("code read outside lock area refused or wrong");
    a_main_write: assert property (
        wrReq && st_q.arm && st_q.wide && xAddr[FLASH_AW-1:0] > LOCK_AREA_END
        && xAddr[FLASH_AW-1:0] <= MAIN_AREA_END |=> flashWrEn)
        else $error("main area write refused with wide flag");

    // requests seen during the stall never start a second write
    a_stall_no_write: assert property (
        coreStall |=> !flashWrEn)
        else $error("write started while core stalled");

    c_write_done: cover property (wrOk ##1 flashWrEn ##[1:300] !coreStall);
    c_write_denied: cover property (wrReq && !xOk);
    c_wide_set: cover property (sfrWrEn && sfrAddr == SFR_SOFT_CMD
        && sfrWrData == WIDE_UNLOCK_KEY);
    c_lock_code: cover property (codeDenied);
    c_main_write: cover property (wrOk && st_q.wide
        && xAddr[FLASH_AW-1:0] <= MAIN_AREA_END);

endmodule

`default_nettype wire

// [verilog/fia_pkg.sv]
/*
  Constants and the state type of the flash in-application access block.
  Assumes a single 200 MHz core clock and a 16K-byte flash behind the block.
*/
`default_nettype none

package fia_pkg;

    // clock and write timing
    localparam int CLK_MHZ = 200;
    localparam int WRITE_MIN_US = 200;
    localparam int WRITE_MAX_US = 500;
    localparam int WRITE_CYCLES = WRITE_MIN_US * CLK_MHZ;

    // special register addresses
    localparam logic [7:0] SFR_SOFT_CMD = 8'h97;
    localparam logic [7:0] SFR_WRITE_ARM = 8'hC9;
    localparam logic [7:0] SFR_CTRL_LOW = 8'hF7;

    // command keys
    localparam logic [7:0] WIDE_UNLOCK_KEY = 8'h65;
    localparam logic [7:0] WRITE_ARM_KEY = 8'h47;

    // field positions
    localparam int WIDE_BIT = 0;
    localparam int ARM_BIT = 7;
    localparam int LOCK_BIT = 1;

    // reset values
    localparam logic WIDE_RST = 1'b0;
    localparam logic ARM_RST = 1'b0;
    localparam logic LOCK_RST = 1'b1;
    localparam logic [7:0] CTRL_LOW_RST = 8'h00;

    // flash map, 14-bit byte address of the 16K space
    localparam int FLASH_AW = 14;
    localparam logic [FLASH_AW-1:0] LOCK_AREA_END = 14'h01FF;
    localparam logic [FLASH_AW-1:0] MAIN_AREA_END = 14'h3EFF;
    localparam logic [FLASH_AW-1:0] FREE_AREA_END = 14'h3FFB;
    localparam logic [FLASH_AW-1:0] CFG_TOP_ADDR = 14'h3FFF;
    localparam logic [1:0] FLASH_WINDOW = 2'h0;

    typedef struct packed {
        logic wide;
        logic arm;
        logic loaded;
        logic lock;
        logic [7:0] ctrlLow;
        logic [7:0] sfrRd;
        logic sfrHit;
        logic [7:0] xRd;
        logic xDen;
        logic [7:0] codeRd;
        logic codeDen;
        logic wrPulse;
        logic [FLASH_AW-1:0] wrAddr;
        logic [7:0] wrData;
    } fia_state_s;

endpackage

`default_nettype wire

// [verilog/fia_region_check.sv]
/*
  Sector permission decode for one flash address.
  Assumes lock and wide-area flags already registered by the caller.
*/
`default_nettype none

module fia_region_check
    import fia_pkg::*;
(
    // address and kind of access
    input wire logic [FLASH_AW-1:0] addr,
    input wire logic dataSpace,
    // permission state
    input wire logic lock,
    input wire logic wide,
    // verdict
    output logic allowed
);

    always_comb
    begin
        if (addr <= LOCK_AREA_END)
            allowed = !lock && (!dataSpace || wide);
        else if (addr <= MAIN_AREA_END)
            allowed = !dataSpace || wide;
        else if (addr <= FREE_AREA_END)
            allowed = 1'b1;
        else if (addr != CFG_TOP_ADDR)
            allowed = !dataSpace || wide;
        else
            allowed = !dataSpace;
    end

endmodule

`default_nettype wire

// [verilog/fia_write_timer.sv]
/*
  Counts the flash write time and holds busy through it.
  Assumes start only while not busy, on the same clock and reset as the caller.
*/
`default_nettype none

module fia_write_timer
    import fia_pkg::*;
#(
    parameter int CYCLES = WRITE_CYCLES,
    parameter int CNT_W = 16
)
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // control
    input wire logic start,
    output logic busy
);

    typedef struct packed {
        logic busy;
        logic [CNT_W-1:0] cnt;
    } fia_timer_s;

    localparam logic [CNT_W-1:0] LOAD = CNT_W'(CYCLES - 1);

    fia_timer_s st_q;
    fia_timer_s st_d;

    always_comb
    begin
        st_d = st_q;
        if (st_q.busy)
        begin
            if (st_q.cnt == '0)
                st_d.busy = 1'b0;
            else
                st_d.cnt = st_q.cnt - CNT_W'(1);
        end
        else if (start)
        begin
            st_d.busy = 1'b1;
            st_d.cnt = LOAD;
        end
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign busy = st_q.busy;

    a_timer_load: assert property (@(posedge core_clk) disable iff (!rstn)
        $rose(st_q.busy) |-> st_q.cnt == LOAD)
        else $error("write timer not loaded with full count");
    a_timer_end: assert property (@(posedge core_clk) disable iff (!rstn)
        st_q.busy && st_q.cnt == '0 |=> !st_q.busy)
        else $error("write timer overran its count");

endmodule

`default_nettype wire

// [testbench/fia_flash_model.sv]
/*
  Flash macro model: 16K bytes, combinational read, byte write on a one-cycle strobe.
  Assumes the access block raises the strobe for a single core_clk cycle per byte.
*/
`default_nettype none

module fia_flash_model
(
    // clock
    input wire logic core_clk,
    // read port
    input wire logic [13:0] rdAddr,
    output logic [7:0] rdData,
    // write port
    input wire logic wrEn,
    input wire logic [13:0] wrAddr,
    input wire logic [7:0] wrData
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [7:0] mem [16384];

    initial
    begin
        for (int i = 0; i < 16384; i++)
            mem[i] = 8'(i) ^ 8'hA5;
    end

    assign rdData = mem[rdAddr];

    // single byte overwrite, no erase beforehand
    always @(posedge core_clk)
    begin
        if (wrEn === 1'b1)
            mem[wrAddr] <= wrData;
    end
endmodule

`default_nettype wire

// [testbench/fia_access_ctrl_bench.sv]
/*
  Self-checking bench: acts as the core, notes expectations in a queue, a monitor compares.
  Assumes the access block with a shortened write time and the flash macro model.
*/
`default_nettype none

module fia_access_ctrl_bench;
    import fia_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int WC = 20;
    logic core_clk = 0, resetn = 0;
    logic [7:0] sfrAddr = 0, sfrWrData = 0, cfgLowByte = 0, cfgHighByte = 0, xWrData = 0;
    logic sfrWrEn = 0, sfrRdEn = 0, xWrEn = 0, xRdEn = 0, codeRdEn = 0;
    logic [15:0] xAddr = 0;
    logic [13:0] codeAddr = 0;
    logic [7:0] sfrRdData, xRdData, codeRdData, ctrlLowByte, flashRdData, flashWrData;
    logic sfrRdHit, xDenied, codeDenied, coreStall, irqHold, flashWrEn;
    logic [13:0] flashRdAddr, flashWrAddr;
    logic [31:0] notes [$];
    logic [7:0] sh [16384];
    logic [13:0] tbl [9] = '{14'h0000, 14'h01FF, 14'h0200, 14'h3EFF, 14'h3F00, 14'h3FFB,
                             14'h3FFC, 14'h3FFE, 14'h3FFF};
    logic lock, wide, arm, pS, pX, pC, pW;
    logic [7:0] ctl;
    int errors = 0, comparisons = 0, stallCnt = 0, cycles = 0, seed;

    always #2.5 core_clk = ~core_clk;

    fia_access_ctrl #(.WRITE_CYC(WC), .CNT_W(16)) fia_access_ctrl_inst (
        .core_clk(core_clk), .resetn(resetn), .sfrAddr(sfrAddr), .sfrWrEn(sfrWrEn),
        .sfrWrData(sfrWrData), .sfrRdEn(sfrRdEn), .sfrRdData(sfrRdData), .sfrRdHit(sfrRdHit),
        .xAddr(xAddr), .xWrEn(xWrEn), .xWrData(xWrData), .xRdEn(xRdEn), .xRdData(xRdData),
        .xDenied(xDenied), .codeAddr(codeAddr), .codeRdEn(codeRdEn),
        .codeRdData(codeRdData), .codeDenied(codeDenied), .coreStall(coreStall),
        .irqHold(irqHold), .cfgLowByte(cfgLowByte), .cfgHighByte(cfgHighByte),
        .ctrlLowByte(ctrlLowByte), .flashRdAddr(flashRdAddr), .flashRdData(flashRdData),
        .flashWrEn(flashWrEn), .flashWrAddr(flashWrAddr), .flashWrData(flashWrData));

    fia_flash_model fia_flash_model_inst (
        .core_clk(core_clk), .rdAddr(flashRdAddr), .rdData(flashRdData),
        .wrEn(flashWrEn), .wrAddr(flashWrAddr), .wrData(flashWrData));

    function automatic logic ok(input logic [13:0] a, input logic d);
        if (a <= 14'h01FF) return !lock && (!d || wide);
        if (a <= 14'h3EFF) return !d || wide;
        if (a <= 14'h3FFB) return 1'b1;
        if (a <= 14'h3FFE) return !d || wide;
        return !d;
    endfunction

    task automatic close_out();
        if (notes.size() != 0)
            errors++;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic cmp_read(input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e)
        begin
            errors++;
            $display("wrong value at %0t: read result %h, expected %h", $time, g, e);
        end
    endtask

    task automatic cmp_write(input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e)
        begin
            errors++;
            $display("wrong value at %0t: write result %h, expected %h", $time, g, e);
        end
    endtask

    task automatic take(input logic [31:0] g);
        logic [31:0] e;
        if (notes.size() == 0)
        begin
            errors++;
            $display("wrong value at %0t: result %h with nothing expected", $time, g);
        end
        else
        begin
            e = notes.pop_front();
            if (e[31:29] >= 3'd3)
                cmp_write(e, g);
            else
                cmp_read(e, g);
        end
    endtask

    always @(posedge core_clk)
    begin
        pS <= sfrRdEn;
        pX <= xRdEn && xAddr[15:14] == 2'h0 && !coreStall;
        pC <= codeRdEn && !coreStall;
        pW <= xWrEn && xAddr[15:14] == 2'h0 && !coreStall;
        cycles++;
        if (cycles == 20000)
        begin
            errors++;
            close_out();
        end
    end

    always @(negedge core_clk)
    begin
        if (coreStall === 1'b1)
            stallCnt++;
        else if (stallCnt != 0)
        begin
            take({3'd4, 29'(stallCnt)});
            stallCnt = 0;
        end
        if (pS)
            take({3'd0, 20'h0, sfrRdHit, sfrRdData});
        if (pX)
            take({3'd1, 20'h0, xDenied, xRdData});
        if (pC)
            take({3'd2, 20'h0, codeDenied, codeRdData});
        if (pW)
            take({6'h18, flashWrEn, xDenied, coreStall, irqHold,
                  flashWrEn ? {flashWrAddr, flashWrData} : 22'h0});
    end

    task automatic step();
        @(posedge core_clk);
        #1;
    endtask

    task automatic do_reset(input logic [7:0] hi);
        resetn = 0;
        cfgHighByte = hi;
        cfgLowByte = 8'($random(seed));
        repeat (6) step();
        resetn = 1;
        repeat (4) step();
        {lock, wide, arm, ctl} = {hi[LOCK_BIT], 2'b00, cfgLowByte};
    endtask

    task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
        {sfrAddr, sfrWrData, sfrWrEn} = {a, d, 1'b1};
        step();
        sfrWrEn = 0;
        if (a == SFR_SOFT_CMD) wide = d == WIDE_UNLOCK_KEY;
        if (a == SFR_WRITE_ARM) arm = d == WRITE_ARM_KEY;
        if (a == SFR_CTRL_LOW) ctl = d;
        step();
    endtask

    task automatic sfr_rd(input logic [7:0] a);
        logic [8:0] e;
        e = a == SFR_SOFT_CMD ? {8'h80, wide} : a == SFR_WRITE_ARM ? {1'b1, arm, 7'h00}
            : a == SFR_CTRL_LOW ? {1'b1, ctl} : 9'h000;
        notes.push_back({3'd0, 20'h0, e});
        {sfrAddr, sfrRdEn} = {a, 1'b1};
        step();
        sfrRdEn = 0;
        step();
        if (a == SFR_CTRL_LOW)
            cmp_read({24'h0, ctl}, {24'h0, ctrlLowByte});
    endtask

    task automatic rd_xc(input logic [13:0] a);
        notes.push_back({3'd1, 20'h0, !ok(a, 1), ok(a, 1) ? sh[a] : 8'h00});
        {xAddr, xRdEn} = {2'b00, a, 1'b1};
        step();
        xRdEn = 0;
        step();
        notes.push_back({3'd2, 20'h0, !ok(a, 0), ok(a, 0) ? sh[a] : 8'h00});
        {codeAddr, codeRdEn} = {a, 1'b1};
        step();
        codeRdEn = 0;
        step();
    endtask

    task automatic sweep();
        for (int i = 0; i < 9; i++)
            rd_xc(tbl[i]);
    endtask

    task automatic wr_x(input logic [13:0] a);
        logic [7:0] d;
        logic go;
        d = 8'($random(seed));
        go = arm && ok(a, 1);
        notes.push_back({6'h18, go, !ok(a, 1), go, go, go ? {a, d} : 22'h0});
        if (go)
        begin
            notes.push_back({3'd4, 29'(WC)});
            sh[a] = d;
        end
        {xAddr, xWrData, xWrEn} = {2'b00, a, d, 1'b1};
        step();
        xWrEn = 0;
        repeat (go ? WC + 3 : 1) step();
    endtask

    initial
    begin
        logic [7:0] k;
        seed = 32'ha49302ae;
        for (int i = 0; i < 16384; i++)
            sh[i] = 8'(i) ^ 8'hA5;
        do_reset(8'h02);
        sfr_rd(8'h97);
        sfr_rd(8'hC9);
        sfr_rd(8'hF7);
        sfr_rd(8'h55);
        sweep();
        wr_x(14'h3F00);
        sfr_wr(8'hC9, 8'h47);
        sfr_rd(8'hC9);
        wr_x(14'h3F00);
        rd_xc(14'h3F00);
        wr_x(14'h0200);
        sfr_wr(8'h97, 8'h65);
        sfr_rd(8'h97);
        sweep();
        wr_x(14'h0200);
        wr_x(14'h3FFF);
        wr_x(14'h0000);
        wr_x(14'h3F00);
        rd_xc(14'h3F00);
        sfr_wr(8'hF7, 8'($random(seed)));
        sfr_rd(8'hF7);
        k = 8'($random(seed));
        sfr_wr(8'h97, k == 8'h65 ? 8'h64 : k);
        sfr_wr(8'hC9, k == 8'h47 ? 8'h46 : k);
        sfr_rd(8'h97);
        sfr_rd(8'hC9);
        wr_x(14'h3F01);
        do_reset(8'hFD);
        sfr_rd(8'hF7);
        sweep();
        sfr_wr(8'h97, 8'h65);
        sweep();
        sfr_wr(8'hC9, 8'h47);
        wr_x(14'h0010);
        rd_xc(14'h0010);
        close_out();
    end
endmodule

`default_nettype wire
